// ===== hdl/opmc_pkg.sv
// constants and types for the optical pulse measurement configuration block
// How it works
// R01 - swap set: red for proximity, single and first dual sample; infrared second.
// R02 - swap clear: infrared for proximity, single and first dual; red second.
// R03 - infrared code is ten bits: low byte plus bits 1:0 of next register.
// R04 - infrared code gives 1024 linear steps up to 250mA; zero is off.
// R05 - red code is nine bits: low byte plus bit 0 of next register.
// R06 - red code gives 512 steps up to 125mA; zero is off.
// R07 - channel one cancel bit adds half-scale offset during infrared integration.
// R08 - channel two cancel bit adds half-scale offset during red integration.
// R09 - average field codes 0..4 give 1..16 samples, 5..7 give 32.
// R10 - samples are averaged before FIFO, cutting write rate by N.
// R11 - pulse width codes 3..7 give 130/247/481/949/949 us; 0..2 reserved.
// R12 - output resolution depends on pulse width and averaged sample count.
// R13 - host programs only permitted pulse width and period pairs.
// R14 - host writes fixed bits at their constant values.
// R15 - period field codes 0..7 give 0.3125 to 20 ms periods.
// R16 - registers read back written values and reset to defaults.
`default_nettype none
package opmc_pkg;
  localparam logic [7:0] ADDR_IR_LOW   = 8'h30;
  localparam logic [7:0] ADDR_IR_HIGH  = 8'h31;
  localparam logic [7:0] ADDR_RED_LOW  = 8'h32;
  localparam logic [7:0] ADDR_RED_HIGH = 8'h33;
  localparam logic [7:0] ADDR_CANCEL   = 8'h34;
  localparam logic [7:0] ADDR_AVG      = 8'h35;
  localparam logic [7:0] ADDR_PWPER    = 8'h36;
  localparam logic [7:0] RST_IR_LOW    = 8'h00;
  localparam logic [7:0] RST_IR_HIGH   = 8'h00;
  localparam logic [7:0] RST_RED_LOW   = 8'h00;
  localparam logic [7:0] RST_RED_HIGH  = 8'h00;
  localparam logic [7:0] RST_CANCEL    = 8'h00;
  localparam logic [7:0] RST_AVG       = 8'h0a;
  localparam logic [7:0] RST_PWPER     = 8'h42;
  localparam int IR_HIGH_BITS  = 2;
  localparam int RED_HIGH_BIT  = 0;
  localparam int CH1_CANCEL_BIT = 2;
  localparam int CH2_CANCEL_BIT = 0;
  localparam int AVG_LSB  = 4;
  localparam int PW_LSB   = 4;
  localparam int PER_LSB  = 0;
  localparam int FIELD_W  = 3;
  localparam int AVG_MAX_LOG2 = 5;
  // pulse widths in microseconds
  localparam logic [9:0] PW_130_US = 10'd130;
  localparam logic [9:0] PW_247_US = 10'd247;
  localparam logic [9:0] PW_481_US = 10'd481;
  localparam logic [9:0] PW_949_US = 10'd949;
  // pulse width codes; codes below the shortest are reserved
  localparam logic [2:0] PW_CODE_130 = 3'h3;
  localparam logic [2:0] PW_CODE_247 = 3'h4;
  localparam logic [2:0] PW_CODE_481 = 3'h5;
  localparam logic [2:0] PW_CODE_949 = 3'h6;
  // output resolution in bits
  localparam logic [4:0] RES_SHORT_1 = 5'h10;
  localparam logic [4:0] RES_SHORT_2 = 5'h11;
  localparam logic [4:0] RES_FULL    = 5'h12;
  localparam int CLK_MHZ = 250;
  typedef enum logic [2:0] {
    OPMC_IDLE   = 3'b001,
    OPMC_FIRST  = 3'b010,
    OPMC_SECOND = 3'b100
  } opmc_seq_t;
endpackage
`default_nettype wire

// ===== hdl/opmc_top.sv
// register file and emitter steering for the optical pulse measurement channel
`default_nettype none
module opmc_top
  import opmc_pkg::*;
#(
  parameter int SAMPLE_W = 18
)
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // register port
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  output logic      [7:0]          reg_rdata,
  output logic                     reg_hit,
  // measurement sequencing
  input  wire logic                proximity_measurement,
  input  wire logic                single_emitter_pulse_mode,
  input  wire logic                dual_emitter_pulse_mode,
  input  wire logic                sample_start,
  input  wire logic                emitter_swap,
  // raw sample in
  input  wire logic                sample_valid,
  input  wire logic [SAMPLE_W-1:0] sample_data,
  // emitter drive
  output logic                     infrared_emitter_pin,
  output logic                     red_emitter_pin,
  output logic      [9:0]          drive_code,
  output logic                     offset_cancel,
  // configuration out
  output logic      [9:0]          infrared_drive_code,
  output logic      [8:0]          red_drive_code,
  output logic      [9:0]          pulse_width_us,
  output logic      [2:0]          measurement_period_select,
  output logic      [4:0]          resolution_bits,
  // averaged result to FIFO
  output logic                     fifo_wr,
  output logic      [SAMPLE_W-1:0] fifo_data
);

  if (SAMPLE_W < 1 || SAMPLE_W > 24)
  begin : g_sample_w_check
    $error("opmc_top: SAMPLE_W out of range");
  end

  // ==========================================================
  // registers
  logic [7:0] ir_drive_low_reg;
  logic [7:0] ir_drive_high_reg;
  logic [7:0] red_drive_low_reg;
  logic [7:0] red_drive_high_reg;
  logic [7:0] offset_cancel_ctrl_reg;
  logic [7:0] averaging_ctrl_reg;
  logic [7:0] pulse_period_ctrl_reg;

  // fixed bits stay as written; the host keeps them at their constants
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ir_drive_low_reg       <= RST_IR_LOW; // R16
      ir_drive_high_reg      <= RST_IR_HIGH;
      red_drive_low_reg      <= RST_RED_LOW;
      red_drive_high_reg     <= RST_RED_HIGH;
      offset_cancel_ctrl_reg <= RST_CANCEL;
      averaging_ctrl_reg     <= RST_AVG;
      pulse_period_ctrl_reg  <= RST_PWPER;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_IR_LOW)
        ir_drive_low_reg <= reg_wdata; // R16
      else if (reg_addr == ADDR_IR_HIGH)
        ir_drive_high_reg <= reg_wdata;
      else if (reg_addr == ADDR_RED_LOW)
        red_drive_low_reg <= reg_wdata;
      else if (reg_addr == ADDR_RED_HIGH)
        red_drive_high_reg <= reg_wdata;
      else if (reg_addr == ADDR_CANCEL)
        offset_cancel_ctrl_reg <= reg_wdata;
      else if (reg_addr == ADDR_AVG)
        averaging_ctrl_reg <= reg_wdata; // R14
      else if (reg_addr == ADDR_PWPER)
        pulse_period_ctrl_reg <= reg_wdata; // R13
    end
  end

  always_comb
  begin
    reg_hit   = 1'b1;
    reg_rdata = 8'h00;
    if (reg_addr == ADDR_IR_LOW)
      reg_rdata = ir_drive_low_reg; // R16
    else if (reg_addr == ADDR_IR_HIGH)
      reg_rdata = ir_drive_high_reg;
    else if (reg_addr == ADDR_RED_LOW)
      reg_rdata = red_drive_low_reg;
    else if (reg_addr == ADDR_RED_HIGH)
      reg_rdata = red_drive_high_reg;
    else if (reg_addr == ADDR_CANCEL)
      reg_rdata = offset_cancel_ctrl_reg;
    else if (reg_addr == ADDR_AVG)
      reg_rdata = averaging_ctrl_reg;
    else if (reg_addr == ADDR_PWPER)
      reg_rdata = pulse_period_ctrl_reg;
    else
      reg_hit = 1'b0;
  end

  // ==========================================================
  // field decode
  logic [FIELD_W-1:0] pw_code;
  logic [FIELD_W-1:0] avg_code;
  logic [FIELD_W-1:0] avg_log2;
  logic [9:0]         pw_decoded;
  logic [4:0]         res_decoded;

  assign pw_code  = pulse_period_ctrl_reg[PW_LSB +: FIELD_W];
  assign avg_code = averaging_ctrl_reg[AVG_LSB +: FIELD_W];

  // codes above the largest count all mean 32 samples
  always_comb
  begin
    if (avg_code > FIELD_W'(AVG_MAX_LOG2))
      avg_log2 = FIELD_W'(AVG_MAX_LOG2); // R09
    else
      avg_log2 = avg_code; // R09
  end

  // reserved codes report zero so an unusable setting is visible
  always_comb
  begin
    if (pw_code == PW_CODE_130)
      pw_decoded = PW_130_US; // R11
    else if (pw_code == PW_CODE_247)
      pw_decoded = PW_247_US;
    else if (pw_code == PW_CODE_481)
      pw_decoded = PW_481_US;
    else if (pw_code >= PW_CODE_949)
      pw_decoded = PW_949_US;
    else
      pw_decoded = 10'h000;
  end

  // only the shortest pulse loses resolution, and only with little averaging
  always_comb
  begin
    res_decoded = RES_FULL; // R12
    if (pw_code == PW_CODE_130 && avg_code == 3'h0)
      res_decoded = RES_SHORT_1;
    else if (pw_code == PW_CODE_130 && avg_code == 3'h1)
      res_decoded = RES_SHORT_2;
  end

  // ==========================================================
  // configuration outputs
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      infrared_drive_code <= {RST_IR_HIGH[IR_HIGH_BITS-1:0], RST_IR_LOW}; // R04
      red_drive_code      <= {RST_RED_HIGH[RED_HIGH_BIT], RST_RED_LOW}; // R06
    end
    else
    begin
      infrared_drive_code <= {ir_drive_high_reg[IR_HIGH_BITS-1:0], ir_drive_low_reg}; // R03
      red_drive_code      <= {red_drive_high_reg[RED_HIGH_BIT], red_drive_low_reg}; // R05
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pulse_width_us            <= PW_247_US;
      measurement_period_select <= RST_PWPER[PER_LSB +: FIELD_W];
      resolution_bits           <= RES_FULL;
    end
    else
    begin
      pulse_width_us            <= pw_decoded; // R11
      measurement_period_select <= pulse_period_ctrl_reg[PER_LSB +: FIELD_W]; // R15
      resolution_bits           <= res_decoded; // R12
    end
  end

  // ==========================================================
  // measurement sequencing
  opmc_seq_t seq_reg;
  opmc_seq_t seq_next;
  logic      mode_any;
  logic      mode_dual;

  assign mode_any  = proximity_measurement || single_emitter_pulse_mode ||
                     dual_emitter_pulse_mode;
  // proximity and single-emitter requests take priority over dual
  assign mode_dual = dual_emitter_pulse_mode && !proximity_measurement &&
                     !single_emitter_pulse_mode;

  always_comb
  begin
    seq_next = seq_reg;
    case (seq_reg)
      OPMC_IDLE:
        if (sample_start && mode_any)
          seq_next = OPMC_FIRST;
      OPMC_FIRST:
        if (sample_valid)
          seq_next = mode_dual ? OPMC_SECOND : OPMC_IDLE;
      OPMC_SECOND:
        if (sample_valid)
          seq_next = OPMC_IDLE;
      default:
        seq_next = OPMC_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      seq_reg <= OPMC_IDLE;
    else
      seq_reg <= seq_next;
  end

  // ==========================================================
  // emitter steering
  // swap must be held steady for a whole measurement
  always_comb
  begin
    infrared_emitter_pin = 1'b0;
    red_emitter_pin      = 1'b0;
    case (seq_reg)
      OPMC_FIRST:
      begin
        infrared_emitter_pin = !emitter_swap; // R02
        red_emitter_pin      = emitter_swap; // R01
      end
      OPMC_SECOND:
      begin
        infrared_emitter_pin = emitter_swap; // R01
        red_emitter_pin      = !emitter_swap; // R02
      end
      default:
      begin
        infrared_emitter_pin = 1'b0;
        red_emitter_pin      = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    drive_code    = 10'h000;
    offset_cancel = 1'b0;
    if (red_emitter_pin)
    begin
      drive_code    = {1'b0, red_drive_code}; // R06
      offset_cancel = offset_cancel_ctrl_reg[CH2_CANCEL_BIT]; // R08
    end
    else if (infrared_emitter_pin)
    begin
      drive_code    = infrared_drive_code; // R04
      offset_cancel = offset_cancel_ctrl_reg[CH1_CANCEL_BIT]; // R07
    end
  end

  // ==========================================================
  // averaging ahead of the result fifo
  localparam int SUM_W = SAMPLE_W + AVG_MAX_LOG2;

  logic [SUM_W-1:0]        sum_reg;
  logic [SUM_W-1:0]        sum_next;
  logic [SUM_W-1:0]        avg_shifted;
  logic [AVG_MAX_LOG2:0]   block_len;
  logic [AVG_MAX_LOG2-1:0] count_reg;
  logic [AVG_MAX_LOG2-1:0] count_last;
  logic                    avg_done;

  assign sum_next    = sum_reg + SUM_W'(sample_data);
  assign avg_shifted = sum_next >> avg_log2;
  assign block_len   = (AVG_MAX_LOG2 + 1)'(1) << avg_log2;
  assign count_last  = AVG_MAX_LOG2'(block_len - 1'b1);
  // greater-or-equal closes a block even after the host shrinks the count
  assign avg_done    = sample_valid && (count_reg >= count_last); // R10

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sum_reg   <= '0;
      count_reg <= '0;
    end
    else if (avg_done)
    begin
      sum_reg   <= '0;
      count_reg <= '0;
    end
    else if (sample_valid)
    begin
      sum_reg   <= sum_next;
      count_reg <= count_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fifo_wr   <= 1'b0;
      fifo_data <= '0;
    end
    else
    begin
      fifo_wr <= avg_done; // R10
      if (avg_done)
        fifo_data <= avg_shifted[SAMPLE_W-1:0];
    end
  end

  // ==========================================================
  // assertions
  AST_SWAP_FIRST : assert property (@(posedge clk) disable iff (rst) // R01
    (seq_reg == OPMC_IDLE && sample_start && mode_any && emitter_swap)
    |=> (red_emitter_pin && !infrared_emitter_pin))
    else $error("swapped first phase not on red emitter");

  AST_SWAP_SECOND : assert property (@(posedge clk) disable iff (rst) // R01
    (seq_reg == OPMC_FIRST && sample_valid && mode_dual && emitter_swap)
    |=> (infrared_emitter_pin && !red_emitter_pin))
    else $error("swapped second phase not on infrared emitter");

  AST_NORMAL_FIRST : assert property (@(posedge clk) disable iff (rst) // R02
    (seq_reg == OPMC_IDLE && sample_start && mode_any && !emitter_swap)
    |=> (infrared_emitter_pin && !red_emitter_pin))
    else $error("normal first phase not on infrared emitter");

  AST_IR_CODE : assert property (@(posedge clk) disable iff (rst) // R03
    1'b1 |=> (infrared_drive_code == {$past(ir_drive_high_reg[1:0]), $past(ir_drive_low_reg)}))
    else $error("infrared code not built from its two registers");

  AST_RED_CODE : assert property (@(posedge clk) disable iff (rst) // R05
    1'b1 |=> (red_drive_code == {$past(red_drive_high_reg[0]), $past(red_drive_low_reg)}))
    else $error("red code not built from its two registers");

  AST_CANCEL_IR : assert property (@(posedge clk) disable iff (rst) // R07
    infrared_emitter_pin |-> (offset_cancel == offset_cancel_ctrl_reg[CH1_CANCEL_BIT]))
    else $error("infrared cancel does not follow its bit");

  AST_CANCEL_RED : assert property (@(posedge clk) disable iff (rst) // R08
    red_emitter_pin |-> (offset_cancel == offset_cancel_ctrl_reg[CH2_CANCEL_BIT]))
    else $error("red cancel does not follow its bit");

  AST_FIFO_FROM_SAMPLE : assert property (@(posedge clk) disable iff (rst) // R10
    fifo_wr |-> $past(sample_valid))
    else $error("fifo write without a closing sample");

  AST_PERIOD : assert property (@(posedge clk) disable iff (rst) // R15
    1'b1 |=> (measurement_period_select == $past(pulse_period_ctrl_reg[2:0])))
    else $error("period select does not follow its field");
endmodule
`default_nettype wire

// ===== testbench/opmc_host.sv
// host model driving the register port
`default_nettype none
module opmc_host (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  input  wire logic       hit,
  output logic            wr = 0,
  output logic            rd = 0,
  output logic      [7:0] addr = 0,
  output logic      [7:0] wdata = 0
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
    // released data no longer shows the last value
    wdata <= ~d;
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    repeat (2) @(posedge clk);
    d = rdata;
    h = hit;
    rd <= 0;
  endtask
endmodule
`default_nettype wire

// ===== testbench/optical_pulse_measurement_config_bench.sv
// random and corner checks of the configuration block
`default_nettype none
module optical_pulse_measurement_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import opmc_pkg::*;
  logic clk = 0, rst = 1, wr, rd, hit, h, sv = 0, fw, st = 0, sw = 0, ip, rp, oc;
  logic pm = 0, sm = 0, dm = 1;
  logic [9:0] dc;
  logic [4:0] res;
  logic [17:0] fd;
  logic [17:0] smp [64];
  int k;
  logic [7:0] a, wd, rdat, d, x;
  logic [9:0] irc, pw;
  logic [8:0] rc;
  logic [2:0] per;
  logic [17:0] sd = '0;
  logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0a, 8'h42};
  int fails = 0, samples_checked = 0, seed = 55372, cyc = 0, n = 0, m;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %0t %h", $time, g); end end
  initial forever #2 clk = ~clk;
  opmc_host u_host (.clk(clk), .rdata(rdat), .hit(hit), .wr(wr), .rd(rd), .addr(a), .wdata(wd));
  opmc_top u_dut (.clk(clk), .rst(rst), .reg_wr(wr), .reg_rd(rd), .reg_addr(a), .reg_wdata(wd),
    .reg_rdata(rdat), .reg_hit(hit), .proximity_measurement(pm),
    .single_emitter_pulse_mode(sm), .dual_emitter_pulse_mode(dm), .sample_start(st),
    .emitter_swap(sw), .sample_valid(sv), .sample_data(sd), .infrared_emitter_pin(ip),
    .red_emitter_pin(rp), .drive_code(dc), .offset_cancel(oc), .infrared_drive_code(irc),
    .red_drive_code(rc), .pulse_width_us(pw), .measurement_period_select(per),
    .resolution_bits(res), .fifo_wr(fw), .fifo_data(fd));
  function automatic logic [9:0] pw_us(input int c);
    return c == 3 ? 10'h082 : c == 4 ? 10'h0f7 : c == 5 ? 10'h1e1 : 10'h3b5;
  endfunction
  // truncated mean of the last 2**lg burst samples
  function automatic logic [17:0] avg_last(input int lg);
    logic [22:0] s;
    s = '0;
    for (int j = 62 - (1 << lg); j < 62; j++)
      s = s + 23'(smp[j]);
    return 18'(s >> lg);
  endfunction
  task automatic final_report;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (fw === 1'b1)
      n <= n + 1;
    if (cyc == 20000)
    begin
      fails++;
      final_report;
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 0;
    `CHK(irc, 10'h000)
    `CHK(rc, 9'h000)
    for (int i = 0; i < 8; i++)
    begin
      u_host.get(8'h30 + 8'(i), d, h);
      if (i < 7) `CHK(d, rv[i])
      `CHK(h, 1'(i < 7))
    end
    for (int i = 0; i < 24; i++)
    begin
      x = i < 2 ? {8{i[0]}} : 8'($random(seed));
      u_host.put(8'h30, x);
      u_host.put(8'h31, x & 8'h03);
      u_host.put(8'h32, ~x);
      u_host.put(8'h33, x & 8'h01);
      u_host.put(8'h34, x & 8'h05);
      u_host.put(8'h36, {1'b0, 3'(3 + i % 5), 1'b0, x[2:0] | 3'h4});
      u_host.put(8'h35, {1'b0, x[6:4], 4'ha});
      repeat (2) @(posedge clk);
      `CHK(irc, {x[1:0], x})
      `CHK(rc, {x[0], ~x})
      `CHK(pw, pw_us(3 + i % 5))
      `CHK(per, x[2:0] | 3'h4)
      u_host.get(8'h34, d, h);
      `CHK(d, x & 8'h05)
      m = n;
      k = x[6:4] > 4 ? 5 : int'(x[6:4]);
      {pm, sm, dm} <= 3'b100 >> (i % 3);
      sw <= x[3];
      @(posedge clk) st <= 1;
      @(posedge clk) st <= 0;
      @(posedge clk);
      `CHK(ip, !sw)
      `CHK(rp, sw)
      `CHK(dc, sw ? {1'b0, x[0], ~x} : {x[1:0], x})
      `CHK(oc, sw ? x[0] : x[2])
      {sv, sd} <= {1'b1, 18'($random(seed))};
      @(posedge clk) sv <= 0;
      @(posedge clk);
      `CHK(ip, dm && sw)
      `CHK(rp, dm && !sw)
      {sv, sd} <= {1'b1, 18'($random(seed))};
      @(posedge clk) sv <= 0;
      for (int j = 0; j < 62; j++)
      begin
        @(posedge clk);
        smp[j] = i < 2 ? {18{i[0]}} : 18'($random(seed));
        {sv, sd} <= {1'b1, smp[j]};
      end
      @(posedge clk) sv <= 0;
      repeat (8) @(posedge clk);
      `CHK(n - m, 64 >> k)
      `CHK(fd, avg_last(k))
      `CHK(res, 5'((i % 5 == 0 && x[6:4] == 0) ? 16 : (i % 5 == 0 && x[6:4] == 1) ? 17 : 18))
    end
    final_report;
  end
endmodule
`default_nettype wire
